// ### hw/lrxpa_pkg.sv
// Package of constants and types for the receive phase aligner
package lrxpa_pkg;
   localparam int         AXI_AW       = 8;
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   // Control field positions
   localparam int         CTRL_MODE_LSB = 0;
   localparam int         CTRL_FACT_LSB = 2;
   localparam int         CTRL_ROLL_LSB = 6;
   localparam int         CTRL_BYP_BIT  = 10;
   localparam int         CTRL_DDR_BIT  = 11;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0229;
   localparam int         PHASES        = 8;
   localparam int         WORD_MAX      = 10;
   localparam logic [3:0] FACT_MIN      = 4'h3;
   localparam logic [3:0] FACT_MAX      = 4'hA;
   localparam logic [3:0] ROLL_MIN      = 4'h1;
   localparam logic [3:0] ROLL_MAX      = 4'hB;
   localparam int         FIFO_DEPTH    = 6;
   localparam logic [2:0] FIFO_WPTR_RST = 3'h3;
   localparam logic [3:0] LOCK_EDGES    = 4'h8;
   localparam logic [1:0] SWITCH_SEEN   = 2'h3;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {
      LRXPA_NON_DYN  = 2'b00,
      LRXPA_DYN      = 2'b01,
      LRXPA_SOFT_CDR = 2'b10
   } lrxpa_mode_t;

   typedef struct packed {
      logic [2:0]          phase;
      logic [2:0]          cand;
      logic [1:0]          cand_cnt;
      logic [3:0]          edge_cnt;
      logic                locked;
      logic                last_smp;
      logic [5:0]          fifo;
      logic [2:0]          wptr;
      logic [2:0]          rptr;
      logic [9:0]          hist;
      logic [3:0]          slip_cnt;
      logic                slip_smp;
      logic                cda_max;
      logic [9:0]          shreg;
      logic [3:0]          bit_cnt;
      logic [9:0]          word;
      logic                word_valid;
      logic                outclk;
      logic [31:0]         ctrl;
      logic                aw_done;
      logic                w_done;
      logic [AXI_AW-1:0]   awaddr;
      logic [31:0]         wdata;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [31:0]         rdata;
   } lrxpa_state_t;
endpackage

// ### hw/lrxpa_top.sv
// Receive phase selector, synchronizer, bit slip and deserializer
// Contract
// - Pick the one of eight 45 degree phases nearest the data centre.
// - Keep watching data phase and move to a better phase when seen.
// - While phase hold is high the chosen phase never changes; code still forces phase 0 on phase reset, bypass or non-dynamic mode.
// - Train on any data with transitions; no fixed pattern needed.
// - Lock flag rises on first lock and stays until phase reset; code also clears it in bypass and in non-dynamic mode.
// - Phase reset returns the selector to untrained; it must retrain.
// - Synchronizer is a 1 bit by 6 entry FIFO absorbing phase offset.
// - FIFO resets on its reset input and when first lock is reached.
// - Each slip request rising edge adds exactly one bit of latency.
// - Realigned words are valid two word clocks after the slip edge.
// - Slip counter wraps after a programmed 1 to 11 bit-times.
// - Rollover flag pulses high for exactly one word clock.
// - Factor 3 to 10, or bypass at double rate or single rate.
// - Bypass: DDR two bits, SDR one bit; no phase select or slip.
// - Non-dynamic: selector and FIFO off, reference phase samples.
// - Dynamic: chosen phase writes FIFO, reference phase reads it.
// - Soft recovery: chosen phase feeds slip directly, clock forwarded.
// - Soft recovery keeps stepping phase; lock flag has no meaning.
// - Words up to ten bits from shift then parallel load registers.
`timescale 1ns/1ps
`default_nettype none
module lrxpa_top
   import lrxpa_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [PHASES-1:0] phase_samples,
   input  wire logic              phase_hold_request,
   input  wire logic              phase_reset,
   input  wire logic              fifo_reset,
   input  wire logic              slip_request,
   output logic [WORD_MAX-1:0]    rx_word,
   output logic                   rx_word_valid,
   output logic                   rx_outclk,
   output logic                   rx_fwd_clk,
   output logic                   rx_locked,
   output logic                   rx_rollover,
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   lrxpa_state_t q;
   lrxpa_state_t d;
   lrxpa_mode_t  mode;
   logic [3:0]   fact;
   logic [3:0]   roll;
   logic         bypass;
   logic         ddr;
   logic         edge_found;
   logic [2:0]   edge_pos;
   logic [2:0]   best;
   logic         sbit;
   logic         sbit_d;
   logic         word_tick;
   logic         slip_edge;
   logic         do_wr;
   logic [31:0]  status;

   // Static settings from the control register, clamped to legal range
   always_comb begin
      mode   = lrxpa_mode_t'(q.ctrl[CTRL_MODE_LSB +: 2]);
      fact   = q.ctrl[CTRL_FACT_LSB +: 4];
      roll   = q.ctrl[CTRL_ROLL_LSB +: 4];
      bypass = q.ctrl[CTRL_BYP_BIT];
      ddr    = q.ctrl[CTRL_DDR_BIT];
      if (fact < FACT_MIN) fact = FACT_MIN;
      if (fact > FACT_MAX) fact = FACT_MAX;
      if (roll < ROLL_MIN) roll = ROLL_MIN;
      if (roll > ROLL_MAX) roll = ROLL_MAX;
   end

   // Edge position among the eight samples of one bit time
   always_comb begin
      edge_found = (q.last_smp != phase_samples[0]);
      edge_pos   = 3'h0;
      for (int k = 1; k < PHASES; k++) begin
         if (!edge_found && phase_samples[k] != phase_samples[k-1]) begin
            edge_found = 1'b1;
            edge_pos   = 3'(k);
         end
      end
      best = edge_pos + 3'h4;
   end

   assign status = {19'h0, q.rptr, q.slip_cnt, q.phase, 2'h0, q.locked};
   assign do_wr  = q.aw_done && q.w_done && !q.bvalid;

   always_comb begin
      d         = q;
      sbit      = 1'b0;
      sbit_d    = 1'b0;
      word_tick = 1'b0;
      slip_edge = 1'b0;
      d.last_smp   = phase_samples[PHASES-1];
      d.word_valid = 1'b0;

      // Phase selector
      if (phase_reset || bypass || mode == LRXPA_NON_DYN) begin
         d.phase    = 3'h0;
         d.cand_cnt = 2'h0;
         d.edge_cnt = 4'h0;
         d.locked   = 1'b0;
      end else if (edge_found) begin
         if (q.edge_cnt != LOCK_EDGES) d.edge_cnt = q.edge_cnt + 4'h1;
         if (q.edge_cnt == LOCK_EDGES - 4'h1) d.locked = 1'b1;
         if (best == q.phase) begin
            d.cand_cnt = 2'h0;
         end else if (best != q.cand) begin
            d.cand     = best;
            d.cand_cnt = 2'h1;
         end else if (q.cand_cnt != SWITCH_SEEN) begin
            d.cand_cnt = q.cand_cnt + 2'h1;
         end
         // Untrained moves at once, trained waits for repeated evidence
         if (!phase_hold_request && best != q.phase &&
             (!q.locked || (best == q.cand && q.cand_cnt == SWITCH_SEEN))) begin
            d.phase    = best;
            d.cand_cnt = 2'h0;
         end
      end

      // Synchronizer FIFO, dynamic mode only
      if (fifo_reset || (d.locked && !q.locked)) begin
         d.wptr = FIFO_WPTR_RST;
         d.rptr = 3'h0;
      end else if (mode == LRXPA_DYN && !bypass) begin
         d.fifo[q.wptr] = phase_samples[q.phase];
         d.wptr = (q.wptr == 3'(FIFO_DEPTH-1)) ? 3'h0 : q.wptr + 3'h1;
         d.rptr = (q.rptr == 3'(FIFO_DEPTH-1)) ? 3'h0 : q.rptr + 3'h1;
      end

      // Serial bit source per mode
      unique case (mode)
         LRXPA_DYN:      sbit = q.fifo[q.rptr];
         LRXPA_SOFT_CDR: sbit = phase_samples[q.phase];
         default:        sbit = phase_samples[0];
      endcase
      if (bypass) sbit = phase_samples[0];

      // Bit slip delay line
      d.hist = {q.hist[8:0], sbit};
      sbit_d = (q.slip_cnt == 4'h0) ? sbit : q.hist[q.slip_cnt - 4'h1];

      // Deserializer: shift register then parallel load
      if (bypass) begin
         d.slip_cnt = 4'h0;
         d.cda_max  = 1'b0;
         if (!ddr) begin
            d.word       = {9'h0, sbit};
            d.word_valid = 1'b1;
            d.bit_cnt    = 4'h0;
         end else begin
            d.shreg   = {q.shreg[8:0], sbit};
            d.bit_cnt = (q.bit_cnt == 4'h0) ? 4'h1 : 4'h0;
            if (q.bit_cnt != 4'h0) begin
               d.word       = {8'h0, q.shreg[0], sbit};
               d.word_valid = 1'b1;
            end
         end
         d.outclk = (d.bit_cnt == 4'h0);
      end else begin
         d.shreg = {q.shreg[8:0], sbit_d};
         if (q.bit_cnt >= fact - 4'h1) begin
            word_tick    = 1'b1;
            d.bit_cnt    = 4'h0;
            d.word       = d.shreg;
            d.word_valid = 1'b1;
         end else begin
            d.bit_cnt = q.bit_cnt + 4'h1;
         end
         for (int b = 0; b < WORD_MAX; b++) begin
            if (4'(b) >= fact) d.word[b] = 1'b0;
         end
         d.outclk = (d.bit_cnt < (fact >> 1));
         if (word_tick) begin
            d.slip_smp = slip_request;
            slip_edge  = slip_request && !q.slip_smp;
            d.cda_max  = 1'b0;
            if (slip_edge) begin
               if (q.slip_cnt >= roll - 4'h1) begin
                  d.slip_cnt = 4'h0;
                  d.cda_max  = 1'b1;
               end else begin
                  d.slip_cnt = q.slip_cnt + 4'h1;
               end
            end
         end
      end

      // AXI4-Lite slave
      if (s_axi_awvalid && !q.aw_done && !q.bvalid) begin
         d.aw_done = 1'b1;
         d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_done && !q.bvalid) begin
         d.w_done = 1'b1;
         d.wdata  = s_axi_wdata;
      end
      if (do_wr) begin
         d.aw_done = 1'b0;
         d.w_done  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = RESP_OKAY;
         if (q.awaddr == OFS_CTRL) begin
            for (int i = 0; i < 4; i++) begin
               if (s_axi_wstrb[i]) d.ctrl[8*i +: 8] = q.wdata[8*i +: 8];
            end
         end else if (q.awaddr != OFS_STATUS) begin
            d.bresp = RESP_SLVERR;
         end
      end else if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp  = RESP_OKAY;
         d.rdata  = 32'h0;
         if (s_axi_araddr == OFS_CTRL) begin
            d.rdata = q.ctrl;
         end else if (s_axi_araddr == OFS_STATUS) begin
            d.rdata = status;
         end else begin
            d.rresp = RESP_SLVERR;
         end
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q      <= '0;
         q.ctrl <= CTRL_RESET;
         q.wptr <= FIFO_WPTR_RST;
      end else begin
         q <= d;
      end
   end

   assign rx_word       = q.word;
   assign rx_word_valid = q.word_valid;
   assign rx_outclk     = q.outclk;
   assign rx_fwd_clk    = (mode == LRXPA_SOFT_CDR) && q.outclk;
   assign rx_locked     = q.locked;
   assign rx_rollover   = q.cda_max;
   assign s_axi_awready = !q.aw_done && !q.bvalid;
   assign s_axi_wready  = !q.w_done && !q.bvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_lock_sticky: assert property (
      q.locked && !phase_reset && mode != LRXPA_NON_DYN && !bypass
      |=> q.locked) else $error("lock flag dropped");
   a_hold_phase: assert property (
      phase_hold_request && !phase_reset && mode != LRXPA_NON_DYN
      && !bypass |=> $stable(q.phase)) else $error("phase moved on hold");
   a_reset_untrain: assert property (
      phase_reset |=> !q.locked && q.phase == 3'h0 && q.edge_cnt == 4'h0)
      else $error("phase reset left state trained");
   a_fifo_on_lock: assert property (
      $rose(q.locked) |-> q.wptr == FIFO_WPTR_RST && q.rptr == 3'h0)
      else $error("fifo not reset on first lock");
   a_fifo_in_range: assert property (
      q.wptr < 3'(FIFO_DEPTH) && q.rptr < 3'(FIFO_DEPTH))
      else $error("fifo pointer out of range");
   a_rollover_width: assert property (
      q.cda_max && !word_tick |=> q.cda_max) else $error("rollover short");
   a_rollover_end: assert property (
      q.cda_max && word_tick |=> !q.cda_max) else $error("rollover long");
   a_slip_step: assert property (
      slip_edge && q.slip_cnt < roll - 4'h1
      |=> q.slip_cnt == $past(q.slip_cnt) + 4'h1)
      else $error("slip did not add one bit");
   a_slip_bound: assert property (
      !bypass |-> q.slip_cnt < roll) else $error("slip count past rollover");
   a_bypass_noslip: assert property (
      bypass |=> q.slip_cnt == 4'h0 && q.phase == 3'h0)
      else $error("slip or phase active in bypass");
   a_word_spacing: assert property (
      q.word_valid && !bypass && $stable(fact) |=> !q.word_valid [*2])
      else $error("word too soon");

   c_first_lock: cover property ($rose(q.locked));
   c_rollover: cover property ($rose(q.cda_max));
   c_phase_step: cover property (q.locked ##1 !$stable(q.phase));
endmodule
`default_nettype wire

// ### tb/lrxpa_tx_model.sv
// Upstream serial transmitter model seen through eight sampling phases
`timescale 1ns/1ps
`default_nettype none
module lrxpa_tx_model
   import lrxpa_pkg::*;
(
   input  wire logic         aclk,
   input  wire logic         rnd_en,
   input  wire logic [2:0]   eye_ofs,
   output logic [PHASES-1:0] phase_samples
);
   integer seed  = 32'h8b79;
   logic   cur_q = 1'b0;
   logic   prv_q = 1'b1;
   int     pos_q = 0;
   // Random bits, or one-hot of period four; edges always present
   always @(posedge aclk) begin
      prv_q <= cur_q;
      cur_q <= rnd_en ? 1'($random(seed)) : (pos_q == 0);
      pos_q <= (pos_q + 1) % 4;
   end
   // Phases ahead of the eye still see the previous bit
   always_comb begin
      for (int p = 0; p < PHASES; p++) begin
         phase_samples[p] = (p < eye_ofs) ? prv_q : cur_q;
      end
   end
endmodule
`default_nettype wire

// ### tb/test_lrxpa_top.sv
// Self-checking bench for the receive phase aligner
`timescale 1ns/1ps
`default_nettype none
module test_lrxpa_top
   import lrxpa_pkg::*;
;
   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic              hold = 1'b0;
   logic              preset = 1'b0;
   logic              freset = 1'b0;
   logic              slip = 1'b0;
   logic              rnd_en = 1'b1;
   logic [2:0]        eye_ofs = 3'h3;
   logic [PHASES-1:0] samples;
   logic [9:0]        rx_word;
   logic              rx_word_valid, rx_outclk, rx_fwd_clk;
   logic              rx_locked, rx_rollover;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic [31:0]       wdata = '0, rdata, rd;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp, rsp;
   logic [9:0]        w0, w1;
   logic [3:0]        ph;
   logic              roll_prev = 1'b0;
   int                error_cnt = 0, num_checks = 0, cyc = 0, i;
   int                roll_hi = 0, roll_ed = 0, fwd_hi = 0;

   always #2.5 aclk = ~aclk;

   lrxpa_tx_model TX (.aclk(aclk), .rnd_en(rnd_en), .eye_ofs(eye_ofs),
      .phase_samples(samples));

   lrxpa_top DUT (.aclk(aclk), .aresetn(aresetn), .phase_samples(samples),
      .phase_hold_request(hold), .phase_reset(preset),
      .fifo_reset(freset), .slip_request(slip), .rx_word(rx_word),
      .rx_word_valid(rx_word_valid), .rx_outclk(rx_outclk),
      .rx_fwd_clk(rx_fwd_clk), .rx_locked(rx_locked),
      .rx_rollover(rx_rollover), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   task wrap_up();
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Word after one slip: stream one bit later, MSB first
   function automatic int rot_model(int w);
      return (w >> 1) | ((w & 1) << 3);
   endfunction

   task axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
      logic aw_hs, w_hs, b_hs;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_hs = 1'b0;
      while (!b_hs) begin
         @(negedge aclk);
         aw_hs = awvalid & awready;
         w_hs = wvalid & wready;
         b_hs = (bvalid === 1'b1);
         rsp = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task axi_rd(input logic [AXI_AW-1:0] a);
      logic ar_hs, r_hs;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_hs = 1'b0;
      while (!r_hs) begin
         @(negedge aclk);
         ar_hs = arvalid & arready;
         r_hs = (rvalid === 1'b1);
         rd = rdata;
         rsp = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   task next_word(output logic [9:0] w);
      do @(negedge aclk); while (rx_word_valid !== 1'b1);
      w = rx_word;
   endtask

   // High one word period, low one word period at factor four
   task slip_pulse();
      @(posedge aclk);
      slip <= 1'b1;
      repeat (4) @(posedge aclk);
      slip <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask

   task wait_lock();
      for (i = 0; i < 400 && rx_locked !== 1'b1; i++) @(posedge aclk);
   endtask

   always @(posedge aclk) begin
      roll_prev <= rx_rollover;
      if (rx_rollover === 1'b1) roll_hi++;
      if (rx_rollover === 1'b1 && roll_prev !== 1'b1) roll_ed++;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(OFS_CTRL);
      chk(rd, CTRL_RESET);
      axi_rd(8'h08);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wait_lock();
      chk(32'(rx_locked), 32'h1);
      axi_wr(OFS_STATUS, 32'h0);
      axi_rd(OFS_STATUS);
      chk(32'(rd[0]), 32'h1);
      ph = {1'b0, rd[5:3]};
      eye_ofs <= 3'h7;
      repeat (300) @(posedge aclk);
      axi_rd(OFS_STATUS);
      chk(32'(rd[5:3] !== ph[2:0]), 32'h1);
      chk(32'(rx_locked), 32'h1);
      freset <= 1'b1;
      @(posedge aclk);
      freset <= 1'b0;
      hold <= 1'b1;
      ph = {1'b0, rd[5:3]};
      eye_ofs <= 3'h2;
      repeat (300) @(posedge aclk);
      axi_rd(OFS_STATUS);
      chk(32'(rd[5:3]), 32'(ph));
      hold <= 1'b0;
      preset <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(rx_locked), 32'h0);
      preset <= 1'b0;
      wait_lock();
      chk(32'(rx_locked), 32'h1);
      rnd_en <= 1'b0;
      eye_ofs <= 3'h0;
      axi_wr(OFS_CTRL, 32'h0000_0110);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      repeat (4) next_word(w0);
      roll_hi = 0;
      roll_ed = 0;
      for (int k = 0; k < 8; k++) begin
         slip_pulse();
         next_word(w1);
         next_word(w1);
         chk(32'(w1), 32'(rot_model(int'(w0))));
         chk(32'($countones(w1[3:0])), 32'h1);
         chk(32'(w1 >> 4), 32'h0);
         w0 = w1;
      end
      chk(roll_ed, 32'h2);
      chk(roll_hi, 32'h8);
      chk(32'(rx_fwd_clk), 32'h0);
      axi_wr(OFS_CTRL, 32'h0000_0112);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      repeat (4) next_word(w1);
      for (int k = 0; k < 8; k++) begin
         @(negedge aclk);
         if (rx_fwd_clk === 1'b1) fwd_hi++;
         chk(32'(rx_fwd_clk), 32'(rx_outclk));
      end
      chk(fwd_hi, 32'h4);
      axi_wr(OFS_CTRL, 32'h0000_0510);
      slip_pulse();
      repeat (12) @(posedge aclk);
      axi_rd(OFS_STATUS);
      chk(32'(rd[9:6]), 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
